// *** verif/d3b_ctl.sv ***
// controller-side model: link clock, command bus and write bursts
`timescale 1ns/1ns
module d3b_ctl
  import d3b_pkg::*;
#(
  parameter int BURST_LAT = 5
) (
  output logic                  ck_out,
  output d3b_bus_t              bus_out,
  output logic                  cke_out,
  output logic                  odt_out,
  output logic      [DQ_W-1:0]  dq_out,
  output logic                  dqs_out,
  input  wire logic [DQ_W-1:0]  dq_in,
  input  wire logic [1:0]       oe_in
);
  logic            run = 1'b0;
  logic            wact = 1'b0;
  logic            ck_q = 1'b0;
  logic [DQ_W-1:0] drv = 16'h0000;
  logic [DQ_W-1:0] wdat = 16'h0000;
  initial begin
    cke_out = 1'b0;
    odt_out = 1'b1;
    bus_out = '{1'b1, CMD_NOP, 3'h0, 14'h0};
  end
  // still until run, so the device must self-initialize
  initial begin
    ck_out = 1'b0;
    #13;
    forever #40 if (run) ck_out = ~ck_out;
  end
  always @(ck_out) ck_q <= #20 ck_out;
  assign dqs_out = wact & ck_q;
  // released lines toggle so a stale value never reads as good data
  always @(posedge ck_out) if (!wact) drv <= ~drv;
  wire [DQ_W-1:0] own_w = wact ? wdat : drv;
  assign dq_out = {oe_in[1] ? dq_in[15:8] : own_w[15:8], oe_in[0] ? dq_in[7:0] : own_w[7:0]};
  task automatic cmd(input d3b_cmd_t c, input logic [2:0] b, input logic [13:0] a);
    @(posedge ck_out) #2 bus_out = '{1'b0, c, b, a};
    @(posedge ck_out) #2 bus_out = '{1'b1, CMD_NOP, 3'h0, 14'h0};
  endtask
  task automatic start();
    cmd(CMD_NOP, 3'h0, 14'h0);
    repeat (5) @(posedge ck_out);
    #2 cke_out = 1'b1;
    repeat (5) @(posedge ck_out);
  endtask
  task automatic wr(input logic [2:0] b, input logic [127:0] w);
    cmd(CMD_WR, b, 14'h1400);
    wact = 1'b1;
    // write state opens one clock before the latency edge; beat 0 at its falling edge
    repeat (BURST_LAT - 1) @(posedge ck_out);
    for (int i = 0; i < BEATS; i++) begin
      #2 wdat = w[16*i +: 16];
      if (i % 2 == 0) @(negedge ck_out);
      else @(posedge ck_out);
    end
    #2 wact = 1'b0;
  endtask
endmodule

// *** verif/tb.sv ***
// self-checking bench of the burst memory device core
`timescale 1ns/1ns
module tb;
  import d3b_pkg::*;
  localparam int IW = 20;
  localparam int BL = 5;
  typedef struct packed {
    logic [2:0] ba;
    logic [1:0] rw;
    logic [2:0] s;
    logic       ch;
    logic       il;
    logic [1:0] bl;
    logic [3:0] n;
  } d3b_row_t;
  logic        REF_CLK_IN = 1'b0;
  logic        RSTN_IN = 1'b1;
  int          failures = 0;
  int          n_checks = 0;
  int          k;
  logic [7:0]  lo, hi;
  logic        loe, hoe, lse, hse, lt, lc, ht, hc, term, done, ck, cke, odt, dqs;
  logic [15:0] dq;
  d3b_bus_t    bus;
  logic [2:0]  mr [3] = '{3'h2, 3'h3, 3'h1};
  d3b_row_t    rows [6] = '{
    '{3'h1, 2'h1, 3'h0, 1'b0, 1'b0, BL_OTF, 4'h8},
    '{3'h1, 2'h1, 3'h3, 1'b1, 1'b0, BL_OTF, 4'h4},
    '{3'h6, 2'h2, 3'h5, 1'b0, 1'b1, BL_OTF, 4'h8},
    '{3'h6, 2'h2, 3'h6, 1'b1, 1'b1, BL_OTF, 4'h4},
    '{3'h1, 2'h1, 3'h7, 1'b1, 1'b0, BL_FIX8, 4'h8},
    '{3'h6, 2'h2, 3'h2, 1'b0, 1'b1, BL_FIX4, 4'h4}};
  always #5 REF_CLK_IN = ~REF_CLK_IN;
  d3b_ctl #(.BURST_LAT(BL)) d3b_ctl_i (.ck_out(ck), .bus_out(bus), .cke_out(cke),
    .odt_out(odt), .dq_out(dq), .dqs_out(dqs), .dq_in({hi, lo}), .oe_in({hoe, loe}));
  d3b_core #(.INIT_WAIT_CYCLES(IW), .BURST_LAT(BL)) d3b_core_i (.REF_CLK_IN(REF_CLK_IN),
    .RSTN_IN(RSTN_IN), .CK_IN(ck), .CKE_IN(cke), .CS_N_IN(bus.cs_n), .CMD_IN(bus.cmd),
    .BA_IN(bus.ba), .ADDR_IN(bus.addr), .ODT_IN(odt), .LOW_BYTE_DATA_LINES_IN(dq[7:0]),
    .LOW_BYTE_DATA_LINES_OUT(lo), .LOW_BYTE_DATA_LINES_OE_OUT(loe),
    .HIGH_BYTE_DATA_LINES_IN(dq[15:8]), .HIGH_BYTE_DATA_LINES_OUT(hi),
    .HIGH_BYTE_DATA_LINES_OE_OUT(hoe), .LOW_BYTE_STROBE_T_IN(lse ? lt : dqs),
    .LOW_BYTE_STROBE_C_IN(lse ? lc : ~dqs), .LOW_BYTE_STROBE_T_OUT(lt),
    .LOW_BYTE_STROBE_C_OUT(lc), .LOW_BYTE_STROBE_OE_OUT(lse),
    .HIGH_BYTE_STROBE_T_IN(hse ? ht : dqs), .HIGH_BYTE_STROBE_C_IN(hse ? hc : ~dqs),
    .HIGH_BYTE_STROBE_T_OUT(ht), .HIGH_BYTE_STROBE_C_OUT(hc),
    .HIGH_BYTE_STROBE_OE_OUT(hse), .TERM_EN_OUT(term), .INIT_DONE_OUT(done));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [15:0] pat(input logic [2:0] b, input logic [1:0] r,
                                      input logic [2:0] c);
    return {b, r, c, ~b, r, c};
  endfunction
  task automatic wr(input logic [2:0] ba, input logic [1:0] rw);
    logic [127:0] w;
    for (int b = 0; b < 8; b++) w[16*b +: 16] = pat(ba, rw, 3'(b));
    d3b_ctl_i.cmd(CMD_ACT, ba, {12'h0, rw});
    d3b_ctl_i.wr(ba, w);
  endtask
  task automatic mrs0(input logic il, input logic [1:0] bl);
    d3b_ctl_i.cmd(CMD_MRS, 3'h0, {5'h0, 1'b1, 4'h0, il, 1'b0, bl});
  endtask
  task automatic rd(input d3b_row_t r);
    logic [2:0] bb;
    logic [2:0] c;
    d3b_ctl_i.cmd(CMD_ACT, r.ba, {12'h0, r.rw});
    d3b_ctl_i.cmd(CMD_RD, r.ba, {1'b0, ~r.ch, 1'b0, 1'b1, 7'h0, r.s});
    repeat (BL - 2) @(posedge ck);
    #20 chk("oe lead", 0, {loe, hoe});
    for (int b = 0; b < r.n; b++) begin
      if (b % 2 == 0) @(posedge ck);
      else @(negedge ck);
      #20 bb = 3'(b);
      c = r.il ? r.s ^ bb : {r.s[2] ^ bb[2], r.s[1:0] + bb[1:0]};
      chk("data", pat(r.ba, r.rw, c), {hi, lo});
      chk("strobe", {~bb[0], bb[0], ~bb[0], bb[0]}, {lt, lc, ht, hc});
      chk("oe", 4'hF, {loe, hoe, lse, hse});
    end
    @(posedge ck);
    #20 chk("oe tail", 0, {loe, hoe});
  endtask
  initial begin
    #100000;
    failures++;
    summarize();
  end
  initial begin
    // a real falling edge, so the link domain resets with its clock still
    #1 RSTN_IN = 1'b0;
    #1 chk("rst oe", 0, {loe, hoe, lse, hse});
    chk("rst strobe", 4'h5, {lt, lc, ht, hc});
    chk("rst term", 0, term);
    repeat (3) @(posedge REF_CLK_IN);
    #2 RSTN_IN = 1'b1;
    repeat (IW - 2) @(posedge REF_CLK_IN);
    #2 chk("done early", 0, done);
    repeat (4) @(posedge REF_CLK_IN);
    #2 chk("done", 1, done);
    d3b_ctl_i.run = 1'b1;
    d3b_ctl_i.cmd(CMD_RD, 3'h0, 14'h0);
    repeat (6) @(posedge ck);
    #2 chk("early oe", 0, {loe, hoe});
    chk("early term", 0, term);
    d3b_ctl_i.start();
    foreach (mr[i]) d3b_ctl_i.cmd(CMD_MRS, mr[i], 14'h0);
    mrs0(1'b0, BL_OTF);
    d3b_ctl_i.cmd(CMD_ZQ, 3'h0, 14'h0400);
    repeat (8) @(posedge ck);
    #2 chk("term", 1, term);
    $display("init test done");
    wr(3'h1, 2'h1);
    wr(3'h6, 2'h2);
    foreach (rows[i]) begin
      mrs0(rows[i].il, rows[i].bl);
      rd(rows[i]);
      $display("read row %0d done", i);
    end
    // second read lands in the latency window and must be dropped
    d3b_ctl_i.cmd(CMD_ACT, 3'h1, 14'h1);
    d3b_ctl_i.cmd(CMD_RD, 3'h1, 14'h1400);
    d3b_ctl_i.cmd(CMD_RD, 3'h1, 14'h1400);
    k = 0;
    for (int i = 0; i < 12; i++) begin
      @(posedge ck);
      #20 k += loe;
      if (i == 1) chk("oe start", 1, loe);
    end
    chk("oe clocks", 2, 16'(k));
    $display("refused read test done");
    summarize();
  end
endmodule

// *** verilog/d3b_core.sv ***
// burst access engine and power-up initialization of the memory device
`timescale 1ns/1ns
module d3b_core
  import d3b_pkg::*;
#(
  parameter int INIT_WAIT_CYCLES = INIT_WAIT_CYC,
  parameter int ROW_KEEP         = 2,
  parameter int BURST_LAT        = 5
) (
  input  wire logic              REF_CLK_IN,
  input  wire logic              RSTN_IN,
  input  wire logic              CK_IN,
  input  wire logic              CKE_IN,
  input  wire logic              CS_N_IN,
  input  wire logic [2:0]        CMD_IN,
  input  wire logic [BANK_W-1:0] BA_IN,
  input  wire logic [ROW_W-1:0]  ADDR_IN,
  input  wire logic              ODT_IN,
  input  wire logic [BYTE_W-1:0] LOW_BYTE_DATA_LINES_IN,
  output logic      [BYTE_W-1:0] LOW_BYTE_DATA_LINES_OUT,
  output logic                   LOW_BYTE_DATA_LINES_OE_OUT,
  input  wire logic [BYTE_W-1:0] HIGH_BYTE_DATA_LINES_IN,
  output logic      [BYTE_W-1:0] HIGH_BYTE_DATA_LINES_OUT,
  output logic                   HIGH_BYTE_DATA_LINES_OE_OUT,
  input  wire logic              LOW_BYTE_STROBE_T_IN,
  input  wire logic              LOW_BYTE_STROBE_C_IN,
  output logic                   LOW_BYTE_STROBE_T_OUT,
  output logic                   LOW_BYTE_STROBE_C_OUT,
  output logic                   LOW_BYTE_STROBE_OE_OUT,
  input  wire logic              HIGH_BYTE_STROBE_T_IN,
  input  wire logic              HIGH_BYTE_STROBE_C_IN,
  output logic                   HIGH_BYTE_STROBE_T_OUT,
  output logic                   HIGH_BYTE_STROBE_C_OUT,
  output logic                   HIGH_BYTE_STROBE_OE_OUT,
  output logic                   TERM_EN_OUT,
  output logic                   INIT_DONE_OUT
);
  localparam int LAT_D = BURST_LAT;
  localparam int IDX_W = BANK_W + ROW_KEEP + COL_W - 3;
  localparam int DEPTH = 1 << IDX_W;

  // position inside the 8-beat word for beat b of a burst
  function automatic logic [2:0] beat_col(input logic [2:0] start, input logic [2:0] b,
                                          input logic intl);
    logic [2:0] c;
    c = intl ? (start ^ b) : {start[2] ^ b[2], 2'(start[1:0] + b[1:0])};
    return c;
  endfunction

  // core domain: self-timed initialization, no link clock needed
  logic [31:0] init_cnt_r;
  logic        core_done_r;
  wire         init_last_w = (init_cnt_r == 32'(INIT_WAIT_CYCLES - 1));

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      init_cnt_r  <= 32'h0;
      core_done_r <= 1'b0;
    end else if (!core_done_r) begin
      init_cnt_r  <= init_last_w ? init_cnt_r : init_cnt_r + 32'h1;
      core_done_r <= init_last_w;
    end
  end
  assign INIT_DONE_OUT = core_done_r;

  AST_INIT_TIME: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    $rose(core_done_r) |-> init_cnt_r == 32'(INIT_WAIT_CYCLES - 1))
    else $error("init finished at wrong count");

  // link domain
  logic       done_s1_r;
  logic       done_s2_r;
  logic       cke_seen_r;
  logic       term_r;
  d3b_state_t st_r;
  d3b_state_t st_nxt;
  logic [1:0] k_r;
  logic [1:0] k_nxt;
  logic [31:0] wait_r;
  logic [1:0] mr_bl_r;
  logic       mr_bt_r;
  logic [7:0] row_open_r;
  logic [ROW_W-1:0]  open_row_r [8];
  logic [BANK_W-1:0] bank_r;
  logic [COL_W-1:0]  col_r;
  logic       chop_r;
  logic       ap_r;
  logic       is_wr_r;
  logic       commit_r;
  logic [DQ_W-1:0] dq_pos_r;
  logic [DQ_W-1:0] dq_neg_r;
  logic [DQ_W-1:0] wr_even_r [4];
  logic [DQ_W-1:0] wr_odd_r  [4];
  logic [DQ_W*BEATS-1:0] mem_r [DEPTH];

  d3b_bus_t bus_w;
  assign bus_w = '{cs_n: CS_N_IN, cmd: d3b_cmd_t'(CMD_IN), ba: BA_IN, addr: ADDR_IN};

  // commands only count once internal init is done and CKE is high
  wire cmd_ok_w = CKE_IN && cke_seen_r && done_s2_r && !bus_w.cs_n;
  wire act_w    = cmd_ok_w && bus_w.cmd == CMD_ACT;
  wire rw_w     = cmd_ok_w && (bus_w.cmd == CMD_RD || bus_w.cmd == CMD_WR) && st_r == ST_IDLE;
  wire pre_w    = cmd_ok_w && bus_w.cmd == CMD_PRE;
  wire mrs0_w   = cmd_ok_w && bus_w.cmd == CMD_MRS && bus_w.ba == MR0_SEL;
  wire chop_w   = (mr_bl_r == BL_OTF) ? !bus_w.addr[BC_BIT] : (mr_bl_r == BL_FIX4);
  wire last_w   = (k_r == (chop_r ? 2'h1 : 2'h3));
  wire [IDX_W-1:0] idx_w = {bank_r, open_row_r[bank_r][ROW_KEEP-1:0], col_r[COL_W-1:3]};
  wire [DQ_W*BEATS-1:0] rd_word_w = mem_r[idx_w];
  wire busy_w   = (st_r == ST_RD) || (st_r == ST_WR);
  wire rd_oe_w  = (st_r == ST_RD);
  // auto precharge may meet an explicit precharge of another bank
  wire [7:0] act_mask_w = act_w ? (8'h01 << bus_w.ba) : 8'h00;
  wire [7:0] pre_mask_w = !pre_w ? 8'h00 : (bus_w.addr[AP_BIT] ? 8'hFF : (8'h01 << bus_w.ba));
  wire [7:0] ap_mask_w  = (busy_w && last_w && ap_r) ? (8'h01 << bank_r) : 8'h00;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: st_nxt = rw_w ? ST_WAIT : ST_IDLE;
      ST_WAIT: st_nxt = (wait_r == 32'h0) ? (is_wr_r ? ST_WR : ST_RD) : ST_WAIT;
      ST_RD:   st_nxt = last_w ? ST_IDLE : ST_RD;
      ST_WR:   st_nxt = last_w ? ST_IDLE : ST_WR;
      default: st_nxt = ST_IDLE;
    endcase
  end
  assign k_nxt = (busy_w && st_nxt == st_r) ? 2'(k_r + 2'h1) : 2'h0;

  // merge captured beats into the stored word; chopped writes keep the half that col_r[2] does not select
  logic [DQ_W*BEATS-1:0] wr_word_w;
  always_comb begin
    wr_word_w = rd_word_w;
    for (int b = 0; b < BEATS; b++) begin
      if (b < 4 || !chop_r) begin
        wr_word_w[beat_col(col_r[2:0], 3'(b), mr_bt_r)*DQ_W +: DQ_W] =
          b[0] ? wr_odd_r[b/2] : wr_even_r[b/2];
      end
    end
  end

  always_ff @(posedge CK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      done_s1_r  <= 1'b0;
      done_s2_r  <= 1'b0;
      cke_seen_r <= 1'b0;
      term_r     <= 1'b0;
    end else begin
      done_s1_r  <= core_done_r;
      done_s2_r  <= done_s1_r;
      cke_seen_r <= cke_seen_r | CKE_IN;
      term_r     <= cke_seen_r && ODT_IN && !rd_oe_w;
    end
  end
  assign TERM_EN_OUT = term_r;

  always_ff @(posedge CK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      mr_bl_r    <= MR_BL_RST;
      mr_bt_r    <= MR_BT_RST;
      row_open_r <= 8'h00;
      for (int i = 0; i < 8; i++) open_row_r[i] <= '0;
    end else begin
      if (mrs0_w) begin
        mr_bl_r <= bus_w.addr[1:0];
        mr_bt_r <= bus_w.addr[MR0_BT_BIT];
      end
      if (act_w) begin
        open_row_r[bus_w.ba] <= bus_w.addr;
      end
      row_open_r <= (row_open_r & ~(pre_mask_w | ap_mask_w)) | act_mask_w;
    end
  end

  always_ff @(posedge CK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_r     <= ST_IDLE;
      k_r      <= 2'h0;
      wait_r   <= 32'h0;
      bank_r   <= '0;
      col_r    <= '0;
      chop_r   <= 1'b0;
      ap_r     <= 1'b0;
      is_wr_r  <= 1'b0;
      commit_r <= 1'b0;
      dq_pos_r <= '0;
    end else begin
      st_r     <= st_nxt;
      k_r      <= k_nxt;
      commit_r <= (st_r == ST_WR) && last_w;
      if (rw_w) begin
        bank_r  <= bus_w.ba;
        col_r   <= bus_w.addr[COL_W-1:0];
        ap_r    <= bus_w.addr[AP_BIT];
        chop_r  <= chop_w;
        is_wr_r <= bus_w.cmd == CMD_WR;
        wait_r  <= 32'(LAT_D - 2);
      end else if (st_r == ST_WAIT) begin
        wait_r <= (wait_r == 32'h0) ? 32'h0 : wait_r - 32'h1;
      end
      if (st_nxt == ST_RD) begin
        dq_pos_r <= rd_word_w[beat_col(col_r[2:0], {k_nxt, 1'b0}, mr_bt_r)*DQ_W +: DQ_W];
      end
      if (st_r == ST_WR) begin
        wr_odd_r[k_r] <= {HIGH_BYTE_DATA_LINES_IN, LOW_BYTE_DATA_LINES_IN};
      end
      // commit lands one clock after the last odd beat is captured
      if (commit_r) begin
        mem_r[idx_w] <= wr_word_w;
      end
    end
  end

  // falling edge carries the odd read beats and captures the even write beats
  always_ff @(negedge CK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      dq_neg_r <= '0;
    end else begin
      if (st_r == ST_RD) begin
        dq_neg_r <= rd_word_w[beat_col(col_r[2:0], {k_r, 1'b1}, mr_bt_r)*DQ_W +: DQ_W];
      end
      if (st_r == ST_WR) begin
        wr_even_r[k_r] <= {HIGH_BYTE_DATA_LINES_IN, LOW_BYTE_DATA_LINES_IN};
      end
    end
  end

  // clock-level select of two flopped beats; strobe follows the clock so it
  // is edge aligned with read data
  wire [DQ_W-1:0] dq_out_w = CK_IN ? dq_pos_r : dq_neg_r;
  wire            dqs_w    = rd_oe_w & CK_IN;
  assign LOW_BYTE_DATA_LINES_OUT     = dq_out_w[BYTE_W-1:0];
  assign HIGH_BYTE_DATA_LINES_OUT    = dq_out_w[DQ_W-1:BYTE_W];
  assign LOW_BYTE_DATA_LINES_OE_OUT  = rd_oe_w;
  assign HIGH_BYTE_DATA_LINES_OE_OUT = rd_oe_w;
  assign LOW_BYTE_STROBE_T_OUT       = dqs_w;
  assign LOW_BYTE_STROBE_C_OUT       = ~dqs_w;
  assign HIGH_BYTE_STROBE_T_OUT      = dqs_w;
  assign HIGH_BYTE_STROBE_C_OUT      = ~dqs_w;
  assign LOW_BYTE_STROBE_OE_OUT      = rd_oe_w;
  assign HIGH_BYTE_STROBE_OE_OUT     = rd_oe_w;

  AST_TERM_OFF: assert property (@(posedge CK_IN) disable iff (!RSTN_IN)
    !cke_seen_r |=> !TERM_EN_OUT)
    else $error("termination on before CKE seen");
  AST_NO_EARLY_CMD: assert property (@(posedge CK_IN) disable iff (!RSTN_IN)
    !done_s2_r |=> st_r == ST_IDLE)
    else $error("burst started before init done");
  AST_RD_LAT: assert property (@(posedge CK_IN) disable iff (!RSTN_IN)
    (rw_w && bus_w.cmd == CMD_RD) |-> ##LAT_D rd_oe_w)
    else $error("read burst not at latency");
  AST_BL8: assert property (@(posedge CK_IN) disable iff (!RSTN_IN)
    ($rose(rd_oe_w) && !chop_r) |-> rd_oe_w[*4] ##1 !rd_oe_w)
    else $error("full burst not four clocks");
  AST_BC4: assert property (@(posedge CK_IN) disable iff (!RSTN_IN)
    ($rose(busy_w) && chop_r) |-> busy_w[*2] ##1 !busy_w)
    else $error("chopped burst not two clocks");
  AST_ROW_OPEN: assert property (@(posedge CK_IN) disable iff (!RSTN_IN)
    act_w |=> row_open_r[$past(BA_IN)] && open_row_r[$past(BA_IN)] == $past(ADDR_IN))
    else $error("active did not open row");
  AST_AUTO_PRE: assert property (@(posedge CK_IN) disable iff (!RSTN_IN)
    (busy_w && last_w && ap_r && !act_w) |=> !row_open_r[$past(bank_r)])
    else $error("auto precharge did not close bank");
  AST_STROBE_PAIR: assert property (@(posedge CK_IN) disable iff (!RSTN_IN)
    LOW_BYTE_STROBE_C_OUT != LOW_BYTE_STROBE_T_OUT &&
    HIGH_BYTE_STROBE_C_OUT != HIGH_BYTE_STROBE_T_OUT)
    else $error("strobe pair not complementary");
  AST_BYTE_LANES: assert property (@(posedge CK_IN) disable iff (!RSTN_IN)
    $rose(LOW_BYTE_DATA_LINES_OE_OUT) |-> HIGH_BYTE_STROBE_OE_OUT && LOW_BYTE_STROBE_OE_OUT)
    else $error("byte lanes not driven together");
endmodule

// *** verilog/d3b_pkg.sv ***
// shared constants and types for the burst memory device model
package d3b_pkg;
  localparam int BANK_W        = 3;
  localparam int ROW_W         = 14;
  localparam int COL_W         = 10;
  localparam int DQ_W          = 16;
  localparam int BYTE_W        = 8;
  localparam int BEATS         = 8;
  localparam int AP_BIT        = 10;
  localparam int BC_BIT        = 12;
  localparam int MR0_BT_BIT    = 3;
  localparam int REF_CLK_MHZ   = 100;
  localparam int INIT_WAIT_US  = 500;
  localparam int INIT_WAIT_CYC = INIT_WAIT_US * REF_CLK_MHZ;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [1:0] MR_BL_RST = BL_FIX8;
  localparam logic       MR_BT_RST = 1'h0;
  localparam logic [2:0] MR0_SEL   = 3'h0;

  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_ZQ  = 3'h6,
    CMD_NOP = 3'h7
  } d3b_cmd_t;

  typedef struct packed {
    logic              cs_n;
    d3b_cmd_t          cmd;
    logic [BANK_W-1:0] ba;
    logic [ROW_W-1:0]  addr;
  } d3b_bus_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_RD   = 4'h4,
    ST_WR   = 4'h8
  } d3b_state_t;
endpackage
